// ===== dv/stp_link_properties.sv
// Checks on the overhead serial link.
// Assumes both ends share hclk and the active-low reset hresetn.
`timescale 1ns/1ps
module stp_link_properties (
    // System
    input wire logic hclk,
    input wire logic hresetn,
    // Link
    input wire logic overhead_serial_clock,
    input wire logic overhead_slot_enable,
    input wire logic overhead_frame_mark,
    input wire logic overhead_serial_in
);
    logic        sclk_d_reg, mark_d_reg, srise, mrise;
    logic        seen_reg, seen_next;
    logic [6:0]  rcnt_reg, rcnt_next;
    logic [11:0] fcnt_reg, fcnt_next;

    // Rises since the mark; parks at 7F so idle frames stay quiet.
    always_comb begin
        srise = overhead_serial_clock && !sclk_d_reg;
        mrise = overhead_frame_mark && !mark_d_reg;
        seen_next = seen_reg || mrise;
        fcnt_next = mrise ? 12'h000 : fcnt_reg + 12'h001;
        rcnt_next = rcnt_reg;
        if (srise && overhead_frame_mark) begin
            rcnt_next = 7'h00;
        end else if (srise && rcnt_reg != 7'h7F) begin
            rcnt_next = rcnt_reg + 7'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sclk_d_reg <= 1'h0;
            mark_d_reg <= 1'h0;
            seen_reg   <= 1'h0;
            rcnt_reg   <= 7'h7F;
            fcnt_reg   <= 12'h000;
        end else begin
            sclk_d_reg <= overhead_serial_clock;
            mark_d_reg <= overhead_frame_mark;
            seen_reg   <= seen_next;
            rcnt_reg   <= rcnt_next;
            fcnt_reg   <= fcnt_next;
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_high_phase;
        overhead_serial_clock [*8] ##1 !overhead_serial_clock;
    endsequence
    sequence s_low_phase;
        !overhead_serial_clock [*8] ##1 overhead_serial_clock;
    endsequence

    property p_clk_high;
        $rose(overhead_serial_clock) |-> s_high_phase;
    endproperty
    property p_clk_low;
        $fell(overhead_serial_clock) |-> s_low_phase;
    endproperty
    property p_en_mark;
        overhead_slot_enable == overhead_frame_mark;
    endproperty
    property p_mark_width;
        $rose(overhead_frame_mark) |-> overhead_frame_mark [*8] ##1 overhead_frame_mark [*8]
            ##1 !overhead_frame_mark;
    endproperty
    property p_mark_after_fall;
        $rose(overhead_frame_mark) |-> !overhead_serial_clock ##[1:8] $rose(overhead_serial_clock);
    endproperty
    property p_frame_period;
        mrise && seen_reg |-> fcnt_reg == 12'h9BF;
    endproperty
    property p_data_on_low;
        $changed(overhead_serial_in) |-> !overhead_serial_clock;
    endproperty
    property p_data_stable_slot;
        overhead_serial_clock && !srise && rcnt_reg inside {[7'h41:7'h48]}
            |-> $stable(overhead_serial_in);
    endproperty

    a_clk_high: assert property (p_clk_high)
        else $error("serial clock high phase wrong");
    a_clk_low: assert property (p_clk_low)
        else $error("serial clock low phase wrong");
    a_en_mark: assert property (p_en_mark)
        else $error("slot enable differs from frame mark");
    a_mark_width: assert property (p_mark_width)
        else $error("frame mark not one serial period");
    a_mark_after_fall: assert property (p_mark_after_fall)
        else $error("frame mark not launched in low phase");
    a_frame_period: assert property (p_frame_period)
        else $error("frame mark spacing wrong");
    a_data_on_low: assert property (p_data_on_low)
        else $error("serial input changed while clock high");
    a_data_stable_slot: assert property (p_data_stable_slot)
        else $error("serial input unstable in Z5 bit slot");
endmodule // stp_link_properties

// ===== dv/sts3c_tx_pointer_and_z5_insert_tb_top.sv
// Bench joining the pointer controller and the Z5 inserter.
// Assumes the bench is the only AHB-Lite master and holds clock enable high.
`timescale 1ns/1ps
module sts3c_tx_pointer_and_z5_insert_tb_top;
    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
        logic [7:0] ctrl;
        logic [7:0] h1;
        logic [7:0] h2;
        logic [1:0] stuff;
        logic [9:0] ptr;
    } stp_row_t;

    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, z5_sent;
    logic        tx_frame_start, tx_pos_stuff, tx_neg_stuff;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [7:0]  tx_h1, tx_h2, tx_z5, z5_value;
    int          n, num_errors, checked;
    logic [7:0]  zv [4] = '{8'h80, 8'h01, 8'hA5, 8'h5A};
    logic [15:0] ridx [5] = '{stp_pkg::IDX_CTRL, stp_pkg::IDX_ARB_HIGH, stp_pkg::IDX_ARB_LOW,
                              stp_pkg::IDX_PTR_STAT, 16'h19B8};
    stp_row_t    rows [10] = '{
        '{8'h6A, 8'h34, 8'h20, 8'h6A, 8'h34, 2'h0, 10'h234},
        '{8'h6A, 8'h34, 8'h04, 8'h68, 8'h9E, 2'h2, 10'h235},
        '{8'h6A, 8'h34, 8'h08, 8'h6B, 8'h60, 2'h1, 10'h234},
        '{8'h03, 8'h0E, 8'h01, 8'h9B, 8'h0E, 2'h0, 10'h30E},
        '{8'h03, 8'h0E, 8'h00, 8'h6B, 8'h0E, 2'h0, 10'h30E},
        '{8'h03, 8'h0E, 8'h04, 8'h69, 8'hA4, 2'h2, 10'h000},
        '{8'h03, 8'h0E, 8'h02, 8'h98, 8'h00, 2'h0, 10'h000},
        '{8'h03, 8'h0E, 8'h00, 8'h68, 8'h00, 2'h0, 10'h000},
        '{8'h95, 8'hFF, 8'h20, 8'h95, 8'hFF, 2'h0, 10'h1FF},
        '{8'h60, 8'h11, 8'h20, 8'h65, 8'hFF, 2'h0, 10'h1FF}
    };

    stp_link_if stp_link_if_i ();
    stp_dev stp_dev_i (
        .hclk(hclk), .hresetn(hresetn), .ce(1'h1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(stp_link_if_i.dev),
        .tx_frame_start(tx_frame_start), .tx_h1(tx_h1), .tx_h2(tx_h2),
        .tx_pos_stuff(tx_pos_stuff), .tx_neg_stuff(tx_neg_stuff), .tx_z5(tx_z5)
    );
    stp_ext stp_ext_i (
        .hclk(hclk), .hresetn(hresetn), .ce(1'h1), .link(stp_link_if_i.ext),
        .z5_value(z5_value), .z5_sent(z5_sent)
    );
    stp_link_properties stp_link_properties_i (
        .hclk(hclk), .hresetn(hresetn),
        .overhead_serial_clock(stp_link_if_i.overhead_serial_clock),
        .overhead_slot_enable(stp_link_if_i.overhead_slot_enable),
        .overhead_frame_mark(stp_link_if_i.overhead_frame_mark),
        .overhead_serial_in(stp_link_if_i.overhead_serial_in)
    );

    always #(stp_pkg::CLK_PERIOD_NS / 2) hclk = ~hclk;

    task automatic end_of_test;
        if (num_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic bail(input string what);
        num_errors++;
        $display("Error %s expected handshake seen timeout", what);
        end_of_test();
    endtask

    task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic wait_ready;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'h1 && n < 50);
        if (n >= 50) bail("hready");
    endtask

    task automatic ahb(input logic w, input logic [15:0] idx, input logic [7:0] wd);
        @(posedge hclk);
        hsel <= 1'h1;
        haddr <= {14'h0000, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready();
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, wd};
        wait_ready();
        rd = hrdata;
        cmp_val("hresp", 32'h0, 32'(hresp));
    endtask

    // Pulses are sampled on the falling edge, once outputs have settled.
    task automatic wait_pulse(input logic sent);
        n = 0;
        do begin
            @(negedge hclk);
            n++;
        end while ((sent ? z5_sent : tx_frame_start) !== 1'h1 && n < 6000);
        if (n >= 6000) bail("pulse");
    endtask

    initial begin
        hclk = 1'h0;
        hresetn = 1'h0;
        hsel = 1'h0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hwdata = 32'h0;
        z5_value = 8'h00;
        num_errors = 0;
        checked = 0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'h1;
        ahb(1'h1, 16'h19B8, 8'hFF);
        for (int i = 0; i < 5; i++) begin
            ahb(1'h0, ridx[i], 8'h00);
            cmp_val("reset read", 32'h0, rd);
        end
        wait_pulse(1'h0);
        cmp_val("reset h1", 32'h60, 32'(tx_h1));
        // A byte set after one transfer rides the next frame and shows a frame later.
        for (int i = 0; i < 6; i++) begin
            wait_pulse(1'h1);
            if (i >= 2) cmp_val("z5", 32'(zv[i - 2]), 32'(tx_z5));
            if (i < 4) z5_value <= zv[i];
        end
        ahb(1'h0, stp_pkg::IDX_Z5_CAPT, 8'h00);
        cmp_val("z5 reg", 32'(zv[3]), rd);
        for (int i = 0; i < 10; i++) begin
            ahb(1'h1, stp_pkg::IDX_ARB_HIGH, rows[i].hi);
            ahb(1'h1, stp_pkg::IDX_ARB_LOW, rows[i].lo);
            ahb(1'h1, stp_pkg::IDX_CTRL, rows[i].ctrl);
            wait_pulse(1'h0);
            cmp_val("h1", 32'(rows[i].h1), 32'(tx_h1));
            cmp_val("h2", 32'(rows[i].h2), 32'(tx_h2));
            cmp_val("stuff", 32'(rows[i].stuff), 32'({tx_pos_stuff, tx_neg_stuff}));
            ahb(1'h0, stp_pkg::IDX_PTR_STAT, 8'h00);
            cmp_val("pointer", 32'(rows[i].ptr), rd);
            ahb(1'h0, stp_pkg::IDX_CTRL, 8'h00);
            cmp_val("control", 32'(rows[i].ctrl & stp_pkg::CTRL_RW_MASK), rd);
        end
        ahb(1'h1, stp_pkg::IDX_CTRL, 8'h14);
        for (int i = 1; i < 4; i++) begin
            wait_pulse(1'h0);
            cmp_val("gated stuff", 32'(i == 3), 32'(tx_pos_stuff));
        end
        cmp_val("gated h2", 32'h55, 32'(tx_h2));
        end_of_test();
    end
endmodule // sts3c_tx_pointer_and_z5_insert_tb_top

// ===== rtl/stp_dev.sv
// Transmit pointer controller with Z5 serial capture port and AHB-Lite
// register slave. Assumes an AHB-Lite master with single word transfers.
`timescale 1ns/1ps
module stp_dev (
    // System
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // Overhead serial link
    stp_link_if.dev          link,
    // Outbound frame overhead
    output logic             tx_frame_start,
    output logic [7:0]       tx_h1,
    output logic [7:0]       tx_h2,
    output logic             tx_pos_stuff,
    output logic             tx_neg_stuff,
    output logic [7:0]       tx_z5
);

    // Serial clock divider and slot counter.
    logic [3:0] div_reg,  div_next;
    logic       sclk_reg, sclk_next;
    logic [7:0] slot_reg, slot_next;
    logic       mark_reg, mark_next;
    logic [1:0] rise_reg, rise_next;
    logic       tick;
    logic       frame_tick;

    always_comb begin
        tick       = (div_reg == stp_pkg::DIV_LAST);
        div_next   = tick ? 4'h0 : div_reg + 4'h1;
        sclk_next  = tick ? ~sclk_reg : sclk_reg;
        slot_next  = slot_reg;
        mark_next  = mark_reg;
        frame_tick = 1'b0;
        // The rise flag is delayed by the input synchroniser latency.
        rise_next  = {rise_reg[0], tick & ~sclk_reg};
        if (tick && sclk_reg) begin
            frame_tick = (slot_reg == stp_pkg::FRAME_LAST);
            slot_next  = frame_tick ? 8'h00 : slot_reg + 8'h01;
            mark_next  = frame_tick;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_reg  <= 4'h0;
            sclk_reg <= 1'b0;
            slot_reg <= 8'h00;
            mark_reg <= 1'b0;
            rise_reg <= 2'h0;
        end else if (ce) begin
            div_reg  <= div_next;
            sclk_reg <= sclk_next;
            slot_reg <= slot_next;
            mark_reg <= mark_next;
            rise_reg <= rise_next;
        end
    end

    assign link.overhead_serial_clock = sclk_reg;
    assign link.overhead_slot_enable  = mark_reg; // RULE1
    assign link.overhead_frame_mark   = mark_reg; // RULE1

    // Z5 capture; the input pin is synchronised before use.
    logic       si_s1_reg, si_s2_reg;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] z5_reg,    z5_next;
    logic       z5_slot;

    always_comb begin
        shift_next = shift_reg;
        z5_next    = z5_reg;
        z5_slot    = (slot_reg >= stp_pkg::Z5_FIRST_SLOT) &&
                     (slot_reg <= stp_pkg::Z5_LAST_SLOT); // RULE6
        if (rise_reg[1] && z5_slot) begin
            shift_next = {shift_reg[6:0], si_s2_reg}; // RULE3
            if (slot_reg == stp_pkg::Z5_LAST_SLOT) begin
                z5_next = {shift_reg[6:0], si_s2_reg}; // RULE4
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            si_s1_reg <= 1'b0;
            si_s2_reg <= 1'b0;
            shift_reg <= 8'h00;
            z5_reg    <= 8'h00;
        end else if (ce) begin
            si_s1_reg <= link.overhead_serial_in;
            si_s2_reg <= si_s1_reg;
            shift_reg <= shift_next;
            z5_reg    <= z5_next;
        end
    end

    // Registers, pending requests and pointer generation.
    logic [7:0]  ctrl_reg,   ctrl_next;
    logic [7:0]  arb_hi_reg, arb_hi_next;
    logic [7:0]  arb_lo_reg, arb_lo_next;
    logic        wr_reg,     wr_next;
    logic [15:0] widx_reg,   widx_next;
    logic [31:0] rdata_reg,  rdata_next;
    logic        pf_reg,     pf_next;
    logic        pp_reg,     pp_next;
    logic        pn_reg,     pn_next;
    logic        pd_reg,     pd_next;
    logic [9:0]  ptr_reg,    ptr_next;
    logic [1:0]  ss_reg,     ss_next;
    logic [1:0]  quiet_reg,  quiet_next;
    logic [7:0]  h1_reg,     h1_next;
    logic [7:0]  h2_reg,     h2_next;
    logic        pos_reg,    pos_next;
    logic        neg_reg,    neg_next;
    logic        fs_reg,     fs_next;
    logic        allow;
    logic        event_now;
    logic [3:0]  ndf;
    logic [9:0]  arb_ptr;
    logic [15:0] ridx;
    logic [7:0]  wb;

    always_comb begin
        ctrl_next   = ctrl_reg;
        arb_hi_next = arb_hi_reg;
        arb_lo_next = arb_lo_reg;
        pf_next     = pf_reg;
        pp_next     = pp_reg;
        pn_next     = pn_reg;
        pd_next     = pd_reg;
        ptr_next    = ptr_reg;
        ss_next     = ss_reg;
        quiet_next  = quiet_reg;
        h1_next     = h1_reg;
        h2_next     = h2_reg;
        pos_next    = pos_reg;
        neg_next    = neg_reg;
        fs_next     = frame_tick;
        event_now   = 1'b0;
        arb_ptr     = {arb_hi_reg[1:0], arb_lo_reg}; // RULE11
        allow       = !ctrl_reg[stp_pkg::CTRL_CHECK] ||
                      (quiet_reg == stp_pkg::CHECK_FRAMES); // RULE7
        ndf         = ctrl_reg[stp_pkg::CTRL_CONT_NDF] ?
                      stp_pkg::NDF_SET : stp_pkg::NDF_NORMAL; // RULE19
        // Frame boundary: one pending event per frame, force first.
        if (frame_tick) begin
            h1_next  = {ndf, ss_reg, ptr_reg[9:8]};
            h2_next  = ptr_reg[7:0];
            pos_next = 1'b0;
            neg_next = 1'b0;
            if (allow && pf_reg) begin
                h1_next   = arb_hi_reg; // RULE9 RULE10
                h2_next   = arb_lo_reg; // RULE11
                ptr_next  = arb_ptr; // RULE8
                ss_next   = arb_hi_reg[3:2];
                pf_next   = 1'b0;
                event_now = 1'b1;
            end else if (allow && pd_reg) begin
                h1_next   = {stp_pkg::NDF_SET, ss_reg, arb_ptr[9:8]}; // RULE18
                h2_next   = arb_ptr[7:0];
                ptr_next  = arb_ptr;
                pd_next   = 1'b0;
                event_now = 1'b1;
            end else if (allow && pp_reg) begin
                h1_next   = {ndf, ss_reg, ptr_reg[9:8] ^ stp_pkg::I_MASK[9:8]}; // RULE13
                h2_next   = ptr_reg[7:0] ^ stp_pkg::I_MASK[7:0]; // RULE13
                pos_next  = 1'b1; // RULE12
                ptr_next  = (ptr_reg == stp_pkg::PTR_MAX) ? 10'h000 : ptr_reg + 10'h001; // RULE14
                pp_next   = 1'b0;
                event_now = 1'b1;
            end else if (allow && pn_reg) begin
                h1_next   = {ndf, ss_reg, ptr_reg[9:8] ^ stp_pkg::D_MASK[9:8]}; // RULE17
                h2_next   = ptr_reg[7:0] ^ stp_pkg::D_MASK[7:0]; // RULE17
                neg_next  = 1'b1; // RULE17
                ptr_next  = (ptr_reg == 10'h000) ? stp_pkg::PTR_MAX : ptr_reg - 10'h001; // RULE17
                pn_next   = 1'b0;
                event_now = 1'b1;
            end
            if (event_now) begin
                quiet_next = 2'h0; // RULE7
            end else if (quiet_reg != stp_pkg::CHECK_FRAMES) begin
                quiet_next = quiet_reg + 2'h1;
            end
        end
        // Write data phase; a new request beats a same-cycle apply.
        wb = hwdata[7:0];
        if (wr_reg) begin
            case (widx_reg)
                stp_pkg::IDX_CTRL: begin
                    if (wb[stp_pkg::CTRL_FORCE] && !ctrl_reg[stp_pkg::CTRL_FORCE]) begin
                        pf_next = 1'b1; // RULE8
                    end
                    if (wb[stp_pkg::CTRL_POS]) begin
                        pp_next = 1'b1; // RULE12
                    end
                    if (wb[stp_pkg::CTRL_NEG]) begin
                        pn_next = 1'b1; // RULE17
                    end
                    if (wb[stp_pkg::CTRL_ONE_NDF]) begin
                        pd_next = 1'b1; // RULE18
                    end
                    // Stuff and single NDF bits are never stored.
                    ctrl_next = wb & stp_pkg::CTRL_RW_MASK; // RULE15
                end
                stp_pkg::IDX_ARB_HIGH: arb_hi_next = wb;
                stp_pkg::IDX_ARB_LOW:  arb_lo_next = wb;
                default: ;
            endcase
        end
        // Address phase; reads are answered with zero wait states.
        wr_next    = hsel && hready && htrans[1] && hwrite;
        widx_next  = haddr[17:2];
        ridx       = haddr[17:2];
        rdata_next = rdata_reg;
        if (hsel && hready && htrans[1] && !hwrite) begin
            case (ridx)
                stp_pkg::IDX_CTRL:     rdata_next = {24'h000000, ctrl_reg};
                stp_pkg::IDX_ARB_HIGH: rdata_next = {24'h000000, arb_hi_reg};
                stp_pkg::IDX_ARB_LOW:  rdata_next = {24'h000000, arb_lo_reg};
                stp_pkg::IDX_PTR_STAT: rdata_next = {22'h000000, ptr_reg}; // RULE16
                stp_pkg::IDX_Z5_CAPT:  rdata_next = {24'h000000, z5_reg};
                default:               rdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg   <= stp_pkg::CTRL_RESET;
            arb_hi_reg <= stp_pkg::ARB_RESET;
            arb_lo_reg <= stp_pkg::ARB_RESET;
            wr_reg     <= 1'b0;
            widx_reg   <= 16'h0000;
            rdata_reg  <= 32'h00000000;
            pf_reg     <= 1'b0;
            pp_reg     <= 1'b0;
            pn_reg     <= 1'b0;
            pd_reg     <= 1'b0;
            ptr_reg    <= stp_pkg::PTR_RESET;
            ss_reg     <= stp_pkg::SS_RESET;
            quiet_reg  <= stp_pkg::CHECK_FRAMES;
            h1_reg     <= 8'h00;
            h2_reg     <= 8'h00;
            pos_reg    <= 1'b0;
            neg_reg    <= 1'b0;
            fs_reg     <= 1'b0;
        end else if (ce) begin
            ctrl_reg   <= ctrl_next;
            arb_hi_reg <= arb_hi_next;
            arb_lo_reg <= arb_lo_next;
            wr_reg     <= wr_next;
            widx_reg   <= widx_next;
            rdata_reg  <= rdata_next;
            pf_reg     <= pf_next;
            pp_reg     <= pp_next;
            pn_reg     <= pn_next;
            pd_reg     <= pd_next;
            ptr_reg    <= ptr_next;
            ss_reg     <= ss_next;
            quiet_reg  <= quiet_next;
            h1_reg     <= h1_next;
            h2_reg     <= h2_next;
            pos_reg    <= pos_next;
            neg_reg    <= neg_next;
            fs_reg     <= fs_next;
        end
    end

    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;
    assign hrdata         = rdata_reg;
    assign tx_frame_start = fs_reg;
    assign tx_h1          = h1_reg;
    assign tx_h2          = h2_reg;
    assign tx_pos_stuff   = pos_reg;
    assign tx_neg_stuff   = neg_reg;
    assign tx_z5          = z5_reg;

endmodule // stp_dev

// ===== rtl/stp_ext.sv
// External Z5 inserter: shifts a byte onto the overhead serial input once
// per frame. Assumes the link signals come from another clock domain.
`timescale 1ns/1ps
module stp_ext (
    // System
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       ce,
    // Overhead serial link
    stp_link_if.ext         link,
    // User side
    input  wire logic [7:0] z5_value,
    output logic            z5_sent
);

    logic       ck_s1_reg, ck_s2_reg, ck_s3_reg;
    logic       en_s1_reg, en_s2_reg;
    logic       fm_s1_reg, fm_s2_reg;
    logic       rise;
    logic       fall;
    stp_pkg::stp_ext_state_t st_reg, st_next;
    logic [6:0] cnt_reg,  cnt_next;
    logic [2:0] bit_reg,  bit_next;
    logic [7:0] data_reg, data_next;
    logic       out_reg,  out_next;
    logic       sent_reg, sent_next;

    always_comb begin
        rise      = ck_s2_reg && !ck_s3_reg;
        fall      = !ck_s2_reg && ck_s3_reg;
        st_next   = st_reg;
        cnt_next  = cnt_reg;
        bit_next  = bit_reg;
        data_next = data_reg;
        out_next  = out_reg;
        sent_next = 1'b0;
        case (st_reg)
            stp_pkg::EXT_IDLE: begin
                if (rise && en_s2_reg && fm_s2_reg) begin // RULE1
                    st_next   = stp_pkg::EXT_WAIT; // RULE2
                    cnt_next  = stp_pkg::Z5_WAIT_CNT; // RULE6
                    data_next = z5_value;
                end
            end
            stp_pkg::EXT_WAIT: begin
                if (rise) begin
                    cnt_next = cnt_reg - 7'h01;
                    if (cnt_reg == 7'h01) begin
                        st_next = stp_pkg::EXT_SHIFT;
                    end
                end
            end
            stp_pkg::EXT_SHIFT: begin
                if (fall) begin
                    out_next  = data_reg[7]; // RULE2 RULE4
                    data_next = {data_reg[6:0], 1'b0};
                    bit_next  = bit_reg + 3'h1;
                    if (bit_reg == 3'h7) begin
                        st_next   = stp_pkg::EXT_IDLE; // RULE5
                        sent_next = 1'b1;
                    end
                end
            end
            default: st_next = stp_pkg::EXT_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ck_s1_reg <= 1'b0;
            ck_s2_reg <= 1'b0;
            ck_s3_reg <= 1'b0;
            en_s1_reg <= 1'b0;
            en_s2_reg <= 1'b0;
            fm_s1_reg <= 1'b0;
            fm_s2_reg <= 1'b0;
            st_reg    <= stp_pkg::EXT_IDLE;
            cnt_reg   <= 7'h00;
            bit_reg   <= 3'h0;
            data_reg  <= 8'h00;
            out_reg   <= 1'b0;
            sent_reg  <= 1'b0;
        end else if (ce) begin
            ck_s1_reg <= link.overhead_serial_clock;
            ck_s2_reg <= ck_s1_reg;
            ck_s3_reg <= ck_s2_reg;
            en_s1_reg <= link.overhead_slot_enable;
            en_s2_reg <= en_s1_reg;
            fm_s1_reg <= link.overhead_frame_mark;
            fm_s2_reg <= fm_s1_reg;
            st_reg    <= st_next;
            cnt_reg   <= cnt_next;
            bit_reg   <= bit_next;
            data_reg  <= data_next;
            out_reg   <= out_next;
            sent_reg  <= sent_next;
        end
    end

    assign link.overhead_serial_in = out_reg;
    assign z5_sent                 = sent_reg;

endmodule // stp_ext

// ===== rtl/stp_link_if.sv
// Overhead serial link between the pointer controller and the inserter.
// Assumes both ends run from their own copy of the system clock.
`timescale 1ns/1ps
interface stp_link_if;
    logic overhead_serial_clock;
    logic overhead_slot_enable;
    logic overhead_frame_mark;
    logic overhead_serial_in;

    modport dev (
        output overhead_serial_clock,
        output overhead_slot_enable,
        output overhead_frame_mark,
        input  overhead_serial_in
    );

    modport ext (
        input  overhead_serial_clock,
        input  overhead_slot_enable,
        input  overhead_frame_mark,
        output overhead_serial_in
    );
endinterface

// ===== rtl/stp_pkg.sv
// Constants shared by the STS-3c transmit pointer controller and the
// external Z5 serial inserter. Assumes a 20 MHz system clock on both ends.
// How it works
// RULE1: Inserter samples enable and frame mark on rising clock.
// RULE2: Both high: wait, then drive Z5 MSB on falling.
// RULE3: Device captures each bit on the following rising edge.
// RULE4: Remaining seven bits follow on next seven falling edges.
// RULE5: After eight bits, resume sampling; repeat every frame.
// RULE6: Wait spans eight earlier bytes; Z5 is ninth.
// RULE7: Check-stuff: events only after three quiet frames.
// RULE8: Pointer force rising edge applies arbitrary pointer next frame.
// RULE9: Forced frame NDF bits come from arbitrary high[7:4].
// RULE10: Forced frame SS bits come from arbitrary high[3:2].
// RULE11: Forced pointer is arbitrary high[1:0] with low byte.
// RULE12: Positive stuff bit inserts stuff byte after H3.
// RULE13: Positive stuff frame inverts the I bits.
// RULE14: After positive stuff the pointer increments by one.
// RULE15: Positive stuff control bit clears itself.
// RULE16: Software reads back the current outbound pointer.
// RULE17: Negative stuff: H3 payload, D inverted, decrement, self-clear.
// RULE18: Single NDF: 1001 with arbitrary pointer, then 0110.
// RULE19: Continuous NDF sends enabled pattern every frame while set.
package stp_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [15:0] IDX_CTRL     = 16'h19B7;
    localparam logic [15:0] IDX_ARB_HIGH = 16'h19BF;
    localparam logic [15:0] IDX_ARB_LOW  = 16'h19C3;
    localparam logic [15:0] IDX_PTR_STAT = 16'h19C7;
    localparam logic [15:0] IDX_Z5_CAPT  = 16'h19CB;

    // Control register fields and reset values.
    localparam int         CTRL_FORCE    = 5;
    localparam int         CTRL_CHECK    = 4;
    localparam int         CTRL_NEG      = 3;
    localparam int         CTRL_POS      = 2;
    localparam int         CTRL_CONT_NDF = 1;
    localparam int         CTRL_ONE_NDF  = 0;
    localparam logic [7:0] CTRL_RW_MASK  = 8'h32;
    localparam logic [7:0] CTRL_RESET    = 8'h00;
    localparam logic [7:0] ARB_RESET     = 8'h00;

    // Pointer coding.
    localparam logic [3:0] NDF_NORMAL = 4'h6;
    localparam logic [3:0] NDF_SET    = 4'h9;
    localparam logic [1:0] SS_RESET   = 2'h0;
    localparam logic [9:0] PTR_RESET  = 10'h000;
    localparam logic [9:0] PTR_MAX    = 10'h30E;
    localparam logic [9:0] I_MASK     = 10'h2AA;
    localparam logic [9:0] D_MASK     = 10'h155;
    localparam logic [1:0] CHECK_FRAMES = 2'h3;

    // Timing of the overhead serial port.
    localparam int         CLK_PERIOD_NS = 50;
    localparam int         SER_PERIOD_NS = 800;
    localparam int         FRAME_NS      = 125000;
    localparam int         SER_HALF_CYC  = SER_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int         FRAME_SER     = FRAME_NS / SER_PERIOD_NS;
    localparam logic [3:0] DIV_LAST      = 4'(SER_HALF_CYC - 1);
    localparam logic [7:0] FRAME_LAST    = 8'(FRAME_SER - 1);
    localparam int         Z5_BYTE_POS   = 9;
    localparam int         Z5_WAIT       = 8 * (Z5_BYTE_POS - 1);
    localparam logic [6:0] Z5_WAIT_CNT   = 7'(Z5_WAIT);
    localparam logic [7:0] Z5_FIRST_SLOT = 8'(Z5_WAIT + 1);
    localparam logic [7:0] Z5_LAST_SLOT  = 8'(Z5_WAIT + 8);

    typedef enum logic [1:0] {EXT_IDLE, EXT_WAIT, EXT_SHIFT} stp_ext_state_t;

endpackage
